// File: oaple_core.sv
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module oaple_core
   import oaple_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);
   oaple_state_t st;
   logic [31:0] w_data, rd_mux;
   logic [15:0] exec_op;
   logic [11:0] exec_addr, next_exec_addr, mem_sw_addr, mem_addr;
   logic [11:0] ptr [PTR_COUNT];
   logic [7:0] aw_addr, work, result, f_addr, mem_wdata, mem_rdata;
   logic [4:0] status;
   logic [3:0] w_strb, bank;
   logic [1:0] pend_sel;
   logic aw_have, w_have, wr_fire, busy, hit_ok, ext_en, pend, mem_we;
   logic is_lit, is_file, is_first, is_second, dest_file, acc_bank;
   // Opcode decode from the latched instruction word
   assign is_lit = exec_op[15:8] == OP_OR_LIT;
   assign is_file = exec_op[15:10] == OP_OR_FILE;
   assign is_first = exec_op[15:6] == OP_PTR_FIRST;
   assign is_second = exec_op[15:12] == OP_PTR_SECOND;
   assign dest_file = exec_op[OP_DEST];
   assign acc_bank = exec_op[OP_ACCESS];
   assign f_addr = exec_op[7:0];
   assign busy = st != S_IDLE;
   assign wr_fire = aw_have && w_have && !bvalid;
   // Write address and data are taken independently, in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         wready <= 1'b1;
         aw_have <= 1'b0;
         w_have <= 1'b0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            aw_addr <= awaddr;
            aw_have <= 1'b1;
            awready <= 1'b0;
         end
         if (wvalid && wready) begin
            w_data <= wdata;
            w_strb <= wstrb;
            w_have <= 1'b1;
            wready <= 1'b0;
         end
         if (wr_fire) begin
            bvalid <= 1'b1;
            bresp <= hit_ok ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            aw_have <= 1'b0;
            w_have <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end
   // Mapped write offsets
   always_comb begin
      hit_ok = 1'b0;
      if (aw_addr == OFS_INSTR || aw_addr == OFS_WORK || aw_addr == OFS_STATUS) begin
         hit_ok = 1'b1;
      end else if (aw_addr == OFS_BANK || aw_addr == OFS_CONFIG || aw_addr == OFS_MEM_ADDR
                   || aw_addr == OFS_MEM_DATA) begin
         hit_ok = 1'b1;
      end
   end
   // Read path; pointers and state are read-only
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (araddr == OFS_INSTR) begin
         rd_mux = {16'h0000, exec_op};
      end else if (araddr == OFS_WORK) begin
         rd_mux = {24'h00_0000, work};
      end else if (araddr == OFS_STATUS) begin
         rd_mux = {27'h000_0000, status};
      end else if (araddr == OFS_BANK) begin
         rd_mux = {28'h000_0000, bank};
      end else if (araddr == OFS_CONFIG) begin
         rd_mux = {31'h0000_0000, ext_en};
      end else if (araddr == OFS_PTR0) begin
         rd_mux = {20'h0_0000, ptr[0]};
      end else if (araddr == OFS_PTR1) begin
         rd_mux = {20'h0_0000, ptr[1]};
      end else if (araddr == OFS_PTR2) begin
         rd_mux = {20'h0_0000, ptr[2]};
      end else if (araddr == OFS_MEM_ADDR) begin
         rd_mux = {20'h0_0000, mem_sw_addr};
      end else if (araddr == OFS_MEM_DATA) begin
         rd_mux = {24'h00_0000, mem_rdata};
      end else if (araddr == OFS_STATE) begin
         rd_mux = {30'h0000_0000, pend, busy};
      end
   end
   // One read at a time; unmapped offsets answer SLVERR with zero data
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= rd_mux;
         rresp <= (araddr > OFS_STATE || araddr[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end
   // Phase sequencer; a write to the instruction register starts one cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= S_IDLE;
         exec_op <= 16'h0000;
      end else begin
         case (st)
            S_IDLE: begin
               if (wr_fire && aw_addr == OFS_INSTR && w_strb[1:0] == 2'h3) begin
                  exec_op <= w_data[15:0];
                  st <= S_Q1;
               end
            end
            S_Q1: st <= S_Q2;
            S_Q2: st <= S_Q3;
            S_Q3: st <= S_Q4;
            default: st <= S_IDLE;
         endcase
      end
   end
   // File address selection in decode phase
   always_comb begin
      next_exec_addr = {bank, f_addr};
      if (!acc_bank) begin
         if (ext_en && f_addr <= ACCESS_SPLIT) begin
            next_exec_addr = ptr[PTR_INDEXED] + {4'h0, f_addr};
         end else if (f_addr <= ACCESS_SPLIT) begin
            next_exec_addr = {ACCESS_LOW_BANK, f_addr};
         end else begin
            next_exec_addr = {ACCESS_HIGH_BANK, f_addr};
         end
      end
   end
   // Decode latches the address, process forms the OR result
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         exec_addr <= 12'h000;
         result <= 8'h00;
      end else if (st == S_Q1) begin
         exec_addr <= next_exec_addr;
      end else if (st == S_Q3) begin
         result <= work | (is_lit ? f_addr : mem_rdata);
      end
   end
   // Work, flags, bank and config; software writes arriving while busy are dropped
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         work <= RST_WORK;
         status <= RST_STATUS;
         bank <= RST_BANK;
         ext_en <= RST_EXT;
         mem_sw_addr <= 12'h000;
      end else if (st == S_Q4) begin
         if (is_lit || (is_file && !dest_file)) begin
            work <= result;
         end
         if (is_lit || is_file) begin
            status[ST_N] <= result[7];
            status[ST_Z] <= result == 8'h00;
         end
      end else if (!busy && wr_fire && w_strb[0]) begin
         if (aw_addr == OFS_WORK) begin
            work <= w_data[7:0];
         end else if (aw_addr == OFS_STATUS) begin
            status <= w_data[4:0];
         end else if (aw_addr == OFS_BANK) begin
            bank <= w_data[3:0];
         end else if (aw_addr == OFS_CONFIG) begin
            ext_en <= w_data[CFG_EXT];
         end else if (aw_addr == OFS_MEM_ADDR && w_strb[1]) begin
            mem_sw_addr <= w_data[11:0];
         end
      end
   end
   // Pointer load: first word arms, second word completes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pend <= 1'b0;
         pend_sel <= 2'h0;
      end else if (st == S_Q4) begin
         pend <= is_first && exec_op[5:4] != 2'h3;
         pend_sel <= exec_op[5:4];
      end
   end
   genvar gi;
   generate
      for (gi = 0; gi < PTR_COUNT; gi++) begin : g_ptr
         // High nibble on the first word, low byte on a matching second word
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               ptr[gi] <= RST_PTR;
            end else if (st == S_Q4 && is_first && exec_op[5:4] == 2'(gi)) begin
               ptr[gi][11:8] <= exec_op[3:0];
            end else if (st == S_Q4 && is_second && pend && pend_sel == 2'(gi)
                         && exec_op[11:8] == OP_PTR_SECOND_ZERO) begin
               ptr[gi][7:0] <= exec_op[7:0];
            end
         end
      end
   endgenerate
   // Memory port: core owns it while busy, software otherwise
   assign mem_addr = busy ? exec_addr : mem_sw_addr;
   assign mem_we = (st == S_Q4 && is_file && dest_file)
      || (!busy && wr_fire && aw_addr == OFS_MEM_DATA && w_strb[0]);
   assign mem_wdata = busy ? result : w_data[7:0];
   oaple_mem u_mem (
      .aclk(aclk),
      .we(mem_we),
      .addr(mem_addr),
      .wdata(mem_wdata),
      .rdata(mem_rdata)
   );
   // Checks; each spans an instruction cycle or ties two signals
   or_lit_work_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (st == S_Q1 && is_lit) |-> ##4 (work == ($past(work, 4) | exec_op[7:0])))
      else $error("literal OR result wrong");
   flags_nz_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (st == S_Q4 && (is_lit || is_file)) |=> (status[ST_Z] == (result == 8'h00))
      && (status[ST_N] == result[7]))
      else $error("N or Z flag wrong");
   flags_kept_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (st == S_Q4) |=> status[ST_OV] == $past(status[ST_OV]) && status[1:0] == $past(status[1:0]))
      else $error("other flag changed");
   or_file_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (st == S_Q3 && is_file) |=> (result == (work | $past(mem_rdata))))
      else $error("file OR result wrong");
   dest_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (st == S_Q3 && is_file && dest_file) |=> mem_we && mem_addr == exec_addr
      && mem_wdata == result ##1 (work == $past(work, 2)))
      else $error("file destination wrong");
   bank_addr_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (st == S_Q2 && is_file && acc_bank) |-> exec_addr == {bank, f_addr})
      else $error("banked address wrong");
   indexed_addr_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (st == S_Q2 && is_file && !acc_bank && ext_en && f_addr <= ACCESS_SPLIT)
      |-> exec_addr == ptr[PTR_INDEXED] + {4'h0, f_addr})
      else $error("indexed address wrong");
   ptr_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (st == S_Q1 && is_first && exec_op[5:4] == 2'h1)
      |-> ##4 (ptr[1][11:8] == exec_op[3:0] && pend))
      else $error("pointer high nibble wrong");
   ptr_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (st == S_Q1 && is_second && pend && pend_sel == 2'h0 && exec_op[11:8] == 4'h0)
      |-> ##4 (ptr[0][7:0] == exec_op[7:0] && !pend))
      else $error("pointer low byte wrong");
   lone_second_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (st == S_Q1 && is_second && !pend) |-> ##4 (work == $past(work, 4)
      && ptr[0] == $past(ptr[0], 4) && ptr[2] == $past(ptr[2], 4)))
      else $error("lone second word not a no-op");
endmodule // oaple_core

// File: oaple_host.sv
`timescale 1ns/1ps
module oaple_host (
   input wire logic aclk,
   output logic [7:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   output logic [7:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   // Bus idle from time zero
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} <= '0;
      {araddr, arvalid, rready} <= '0;
   end

   // Address and data offered together; each dropped only at its own taking edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
      bit ad;
      bit dd;
      ad = 0;
      dd = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(ad && dd)) begin
         @(posedge aclk);
         if (awvalid && awready) begin
            ad = 1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            dd = 1;
            wvalid <= 1'b0;
         end
      end
      // No fixed latency assumed; the bench watchdog cuts a hang
      do @(posedge aclk); while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask

   // Read: address held until taken, data captured at the rvalid edge
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask
endmodule // oaple_host

// File: oaple_mem.sv
`timescale 1ns/1ps
module oaple_mem
   import oaple_pkg::*;
(
   input wire logic aclk,
   input wire logic we,
   input wire logic [MEM_AW-1:0] addr,
   input wire logic [MEM_DW-1:0] wdata,
   output logic [MEM_DW-1:0] rdata
);
   logic [MEM_DW-1:0] cells [2**MEM_AW];

   // Registered read, old data on a write to the same cell
   always_ff @(posedge aclk) begin
      if (we) begin
         cells[addr] <= wdata;
      end
      rdata <= cells[addr];
   end
endmodule // oaple_mem

// File: oaple_pkg.sv
package oaple_pkg;
   // Register byte offsets on the AXI4-Lite slave
   localparam logic [7:0] OFS_INSTR = 8'h00;
   localparam logic [7:0] OFS_WORK = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_BANK = 8'h0C;
   localparam logic [7:0] OFS_CONFIG = 8'h10;
   localparam logic [7:0] OFS_PTR0 = 8'h14;
   localparam logic [7:0] OFS_PTR1 = 8'h18;
   localparam logic [7:0] OFS_PTR2 = 8'h1C;
   localparam logic [7:0] OFS_MEM_ADDR = 8'h20;
   localparam logic [7:0] OFS_MEM_DATA = 8'h24;
   localparam logic [7:0] OFS_STATE = 8'h28;
   // Field positions
   localparam int ST_N = 4;
   localparam int ST_OV = 3;
   localparam int ST_Z = 2;
   localparam int ST_DC = 1;
   localparam int ST_C = 0;
   localparam int CFG_EXT = 0;
   localparam int STATE_BUSY = 0;
   localparam int STATE_PEND = 1;
   localparam int OP_DEST = 9;
   localparam int OP_ACCESS = 8;
   // Opcode patterns
   localparam logic [7:0] OP_OR_LIT = 8'h09;
   localparam logic [5:0] OP_OR_FILE = 6'h04;
   localparam logic [9:0] OP_PTR_FIRST = 10'h3B8;
   localparam logic [3:0] OP_PTR_SECOND = 4'hF;
   localparam logic [3:0] OP_PTR_SECOND_ZERO = 4'h0;
   // Addressing limits
   localparam logic [7:0] ACCESS_SPLIT = 8'h5F;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
   localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
   localparam logic [1:0] PTR_INDEXED = 2'h2;
   localparam int PTR_COUNT = 3;
   // Memory shape
   localparam int MEM_AW = 12;
   localparam int MEM_DW = 8;
   // Reset values
   localparam logic [7:0] RST_WORK = 8'h00;
   localparam logic [4:0] RST_STATUS = 5'h00;
   localparam logic [3:0] RST_BANK = 4'h0;
   localparam logic RST_EXT = 1'b0;
   localparam logic [11:0] RST_PTR = 12'h000;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Phases of one instruction cycle
   typedef enum logic [2:0] {S_IDLE, S_Q1, S_Q2, S_Q3, S_Q4} oaple_state_t;
endpackage

// File: or_and_pointer_load_execute_test.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin err_count++; \
   $display("[ERR] %0t got %h expected %h", $time, got, exp); end end
module or_and_pointer_load_execute_test;
   import oaple_pkg::*;
   logic aclk;
   logic aresetn;
   logic [7:0] awaddr, araddr;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata, dat;
   logic [3:0] wstrb, bank;
   logic [1:0] bresp, rresp, resp;
   logic [7:0] w, k, v, f;
   logic [4:0] st;
   logic [11:0] p, ad;
   logic [11:0] ptr [3] = '{12'h000, 12'h000, 12'h000};
   logic d, a, ext;
   int err_count = 0;
   int cmp_count = 0;

   oaple_core oaple_core_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready));
   oaple_host oaple_host_inst (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

   // Status after an OR: only N and Z follow the result
   function automatic logic [4:0] exp_status(input logic [4:0] old, input logic [7:0] r);
      exp_status = old;
      exp_status[ST_N] = r[7];
      exp_status[ST_Z] = (r == 8'h00);
   endfunction

   // Effective file address for the OR-with-file form
   function automatic logic [11:0] exp_addr(input logic [7:0] fa, input logic acc,
      input logic ex, input logic [3:0] bk, input logic [11:0] p2);
      if (acc) exp_addr = {bk, fa};
      else if (ex && fa <= ACCESS_SPLIT) exp_addr = p2 + {4'h0, fa};
      else if (fa <= ACCESS_SPLIT) exp_addr = {ACCESS_LOW_BANK, fa};
      else exp_addr = {ACCESS_HIGH_BANK, fa};
   endfunction

   task automatic wr(input logic [7:0] ra, input logic [31:0] rv);
      oaple_host_inst.wr(ra, rv, resp);
   endtask
   task automatic rd(input logic [7:0] ra);
      oaple_host_inst.rd(ra, dat, resp);
   endtask
   // Start one instruction, then poll until the core reports idle
   task automatic run(input logic [15:0] op);
      int n;
      n = 0;
      wr(OFS_INSTR, {16'h0000, op});
      `CHK(resp, RESP_OKAY)
      do begin
         rd(OFS_STATE);
         n++;
      end while (dat[STATE_BUSY] !== 1'b0 && n < 20);
      `CHK(dat[STATE_BUSY], 1'b0)
      `CHK(resp, RESP_OKAY)
   endtask
   task automatic getmem(input logic [11:0] ma);
      wr(OFS_MEM_ADDR, {20'h0, ma});
      rd(OFS_MEM_DATA);
   endtask

   task automatic finish_test();
      if (err_count == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Clock at 100 MHz
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   // Watchdog sized well above the roughly 1300 cycles the tests need
   initial begin
      #400000;
      err_count++;
      finish_test();
   end

   // Main sequence
   initial begin
      aresetn <= 1'b0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      void'($urandom(46623));
      // Every register but the instruction word and the memory cell starts at zero
      for (int i = 1; i <= 10; i++) begin
         if (i != 9) begin
            rd(8'(4 * i));
            `CHK(dat, 32'h0)
         end
      end
      // Unmapped or misaligned places answer with an error
      rd(8'h30);
      `CHK(resp, RESP_SLVERR)
      rd(8'h05);
      `CHK(resp, RESP_SLVERR)
      wr(8'h34, 32'hFF);
      `CHK(resp, RESP_SLVERR)
      // Literal OR, first pass all zero so the zero flag must set
      for (int i = 0; i < 10; i++) begin
         w = (i == 0) ? 8'h00 : 8'($urandom);
         k = (i == 0) ? 8'h00 : 8'($urandom);
         st = 5'($urandom);
         wr(OFS_WORK, {24'h0, w});
         wr(OFS_STATUS, {27'h0, st});
         run({OP_OR_LIT, k});
         rd(OFS_WORK);
         `CHK(dat[7:0], w | k)
         rd(OFS_STATUS);
         `CHK(dat[4:0], exp_status(st, w | k))
      end
      // Pointer load: high nibble lands first, low byte second
      for (int i = 0; i < PTR_COUNT; i++) begin
         p = 12'($urandom);
         run({OP_PTR_FIRST, 2'(i), p[11:8]});
         `CHK(dat[STATE_PEND], 1'b1)
         rd(OFS_PTR0 + 8'(4 * i));
         `CHK(dat[11:0], {p[11:8], ptr[i][7:0]})
         run({OP_PTR_SECOND, OP_PTR_SECOND_ZERO, p[7:0]});
         `CHK(dat[STATE_PEND], 1'b0)
         rd(OFS_PTR0 + 8'(4 * i));
         `CHK(dat[11:0], p)
         ptr[i] = p;
      end
      // A lone second word must leave everything alone
      w = 8'($urandom);
      wr(OFS_WORK, {24'h0, w});
      run(16'hF05A);
      `CHK(dat[STATE_PEND], 1'b0)
      for (int i = 0; i < PTR_COUNT; i++) begin
         rd(OFS_PTR0 + 8'(4 * i));
         `CHK(dat[11:0], ptr[i])
      end
      rd(OFS_WORK);
      `CHK(dat[7:0], w)
      // File OR; first four passes sit on both sides of the split address
      for (int i = 0; i < 20; i++) begin
         f = (i < 4) ? ACCESS_SPLIT + 8'(i % 2) : 8'($urandom);
         ext = (i < 4) ? 1'(i / 2) : 1'($urandom);
         a = (i < 4) ? 1'b0 : 1'($urandom);
         d = 1'($urandom);
         bank = 4'($urandom);
         {w, v, st} = 21'($urandom);
         wr(OFS_CONFIG, {31'h0, ext});
         wr(OFS_BANK, {28'h0, bank});
         wr(OFS_WORK, {24'h0, w});
         wr(OFS_STATUS, {27'h0, st});
         ad = exp_addr(f, a, ext, bank, ptr[2]);
         wr(OFS_MEM_ADDR, {20'h0, ad});
         wr(OFS_MEM_DATA, {24'h0, v});
         run({OP_OR_FILE, d, a, f});
         rd(OFS_WORK);
         `CHK(dat[7:0], d ? w : (w | v))
         getmem(ad);
         `CHK(dat[7:0], d ? (w | v) : v)
         rd(OFS_STATUS);
         `CHK(dat[4:0], exp_status(st, w | v))
      end
      finish_test();
   end
endmodule // or_and_pointer_load_execute_test
